// file: common/sar_adc_pkg.sv
// Purpose: Shared constants and types of the converter control block
// Assumes: Wishbone register offsets are byte addresses
// Notes:   Field positions refer to the control and status words
package sar_adc_pkg;

	////////////////////////////////////////////////////////////////////
	// Register offsets and reset values
	localparam logic [7:0]  CTRL_ADDR    = 8'h00;
	localparam logic [7:0]  RANGE_ADDR   = 8'h04;
	localparam logic [7:0]  STATUS_ADDR  = 8'h08;
	localparam logic [1:0]  MODE_RESET   = 2'h0;
	localparam logic        REF_RESET    = 1'h0;
	localparam logic [1:0]  PD_RESET     = 2'h0;
	localparam logic        CODING_RESET = 1'h0;
	localparam logic [7:0]  RANGE_RESET  = 8'h00;

	////////////////////////////////////////////////////////////////////
	// Control and status word fields
	localparam int CTRL_MODE_LSB    = 0;
	localparam int CTRL_REF_BIT     = 2;
	localparam int CTRL_PD_LSB      = 3;
	localparam int CTRL_CODING_BIT  = 5;
	localparam int CTRL_SEQ_BIT     = 6;
	localparam int CTRL_CHAN_LSB    = 7;
	localparam int CTRL_SEQLAST_LSB = 9;
	localparam int STAT_FRESH_BIT   = 16;
	localparam int STAT_CORE_BIT    = 17;
	localparam int STAT_REFBUF_BIT  = 18;

	////////////////////////////////////////////////////////////////////
	// Encodings
	localparam logic [1:0] MODE_SINGLE  = 2'h0;
	localparam logic [1:0] MODE_PSEUDO3 = 2'h1;
	localparam logic [1:0] MODE_DIFF2   = 2'h2;
	localparam logic [1:0] MODE_PSEUDO2 = 2'h3;
	localparam logic [1:0] PD_NORMAL    = 2'h0;
	localparam logic [1:0] PD_STANDBY   = 2'h1;
	localparam logic [1:0] PD_SHUTDOWN  = 2'h2;
	localparam logic [1:0] PD_FULL      = 2'h3;
	localparam logic [1:0] RANGE_BIP10  = 2'h0;
	localparam logic [1:0] RANGE_BIP5   = 2'h1;
	localparam logic [1:0] RANGE_BIP2P5 = 2'h2;
	localparam logic [1:0] RANGE_UNI10  = 2'h3;

	////////////////////////////////////////////////////////////////////
	// Conversion figures
	localparam int          CODE_COUNT  = 8192;
	localparam int          RESULT_BITS = $clog2(CODE_COUNT);
	localparam logic [12:0] SAR_START   = 13'h1000;
	localparam logic [4:0]  LAST_DECIDE = 5'h0C;
	localparam logic [4:0]  TRACK_EDGE  = 5'h0E;
	localparam int          LSB_UV_BIP10  = 2441;
	localparam int          LSB_UV_BIP5   = 1220;
	localparam int          LSB_UV_BIP2P5 = 610;
	localparam int          LSB_UV_UNI10  = 1220;

	typedef enum logic [2:0] {
		SAR_CONV  = 3'b001,
		SAR_DONE  = 3'b010,
		SAR_TRACK = 3'b100
	} sar_state_t;

endpackage

// file: logic/sar_convert_engine.sv
// Purpose: Successive approximation sequencer on the serial clock
// Assumes: compHigh settles within one serial clock period
// Notes:   Frame state is cleared while chip select is high
`timescale 1ns/1ps
module sar_convert_engine
	import sar_adc_pkg::*;
(
	// Link clock and frame
	input  wire logic        sclk,
	input  wire logic        csN,
	// Comparator and DAC
	input  wire logic        compHigh,
	output      logic [12:0] dacCode,
	// Conversion state
	output      logic        holdOn,
	output      logic        convDone,
	output      logic [12:0] result,
	output      logic [4:0]  edgeCount
);

	typedef struct packed {
		sar_state_t  state;
		logic [4:0]  count;
		logic [12:0] approx;
	} sar_t;

	localparam sar_t SAR_RESET = '{SAR_CONV, 5'h00, SAR_START};

	sar_t s;
	sar_t next_s;
	logic [12:0] bitMask;

	////////////////////////////////////////////////////////////////////
	// Bit decisions, one per rising serial clock edge
	always_comb
	begin
		next_s = s;
		bitMask = 13'(SAR_START >> s.count);
		next_s.count = (s.count == 5'h1F) ? s.count : 5'(s.count + 5'h01);
		unique case (s.state)
			SAR_CONV:
			begin
				if (!compHigh)
					next_s.approx = s.approx & ~bitMask;
				if (s.count != LAST_DECIDE)
					next_s.approx = next_s.approx | (bitMask >> 1);
				else
					next_s.state = SAR_DONE;
			end
			SAR_DONE:
				next_s.state = SAR_TRACK;
			SAR_TRACK:
				next_s.state = SAR_TRACK;
		endcase
	end

	always_ff @(posedge sclk or posedge csN)
	begin
		if (csN)
			s <= SAR_RESET;
		else
			s <= next_s;
	end

	assign dacCode   = s.approx;
	assign holdOn    = !csN && (s.count < TRACK_EDGE);
	assign convDone  = (s.state != SAR_CONV);
	assign result    = {~s.approx[12], s.approx[11:0]};
	assign edgeCount = s.count;

endmodule // sar_convert_engine

// file: logic/sar_adc_config_control.sv
// Purpose: Configuration, coding and frame control of a 4-channel SAR
// Assumes: Wishbone classic slave on clock, link logic on sclk
// Notes:   Configuration and results cross by toggle handshakes
//
// Summary of operation
// - Each channel has its own range
// - Mode bits pick the input arrangement
// - Single-ended after power-up until rewritten
// - Serial clock runs conversion and shifts data
// - External reference unless internal is selected
// - Power-down selection gates power between frames
// - Twos complement output when coding clear
// - Straight binary output when coding set
// - Last written coding applies to whole sequence
// - 8192 codes across each full-scale range
// - Conversion done when approximation completes
// - Track again at fourteenth serial edge
// - Chip select fall holds and converts
// - Differential codes span -4096 to +4095
`timescale 1ns/1ps
module sar_adc_config_control
	import sar_adc_pkg::*;
(
	// System
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [3:0]  sel_i,
	output      logic        ack_o,
	output      logic [31:0] dat_o,
	// Serial link
	input  wire logic        sclk,
	input  wire logic        csN,
	output      logic        dout,
	// Converter core
	input  wire logic        compHigh,
	output      logic [12:0] dacCode,
	output      logic        holdOn,
	// Input routing
	output      logic [1:0]  muxPos,
	output      logic [1:0]  muxNeg,
	output      logic        negGround,
	output      logic        diffMode,
	output      logic [1:0]  rangeSel,
	// Reference and power
	output      logic        refInternal,
	output      logic        coreOn,
	output      logic        refBufOn
);

	////////////////////////////////////////////////////////////////////
	// State of the register clock domain
	typedef struct packed {
		logic [1:0]  mode;
		logic        refSel;
		logic [1:0]  pdMode;
		logic        coding;
		logic        seqOn;
		logic [1:0]  chanSel;
		logic [1:0]  seqLast;
		logic [7:0]  range;
		logic        cfgToggle;
		logic        ack;
		logic [31:0] rdData;
		logic        resS1;
		logic        resS2;
		logic        resSeen;
		logic [15:0] result;
		logic        fresh;
		logic        csS1;
		logic        csS2;
		logic        coreOn;
		logic        refBufOn;
	} ck_t;

	// State of the link clock domain
	typedef struct packed {
		logic        rstS1;
		logic        rstS2;
		logic        cfgS1;
		logic        cfgS2;
		logic        cfgSeen;
		logic [1:0]  mode;
		logic        coding;
		logic        seqOn;
		logic [1:0]  seqLast;
		logic [7:0]  range;
		logic [1:0]  chan;
		logic        prevDone;
		logic [15:0] resWord;
		logic        resToggle;
		logic [15:0] shift;
		logic [1:0]  muxPos;
		logic [1:0]  muxNeg;
		logic        negGround;
		logic        diffMode;
		logic [1:0]  rangeSel;
	} lk_t;

	ck_t ck;
	ck_t next_ck;
	lk_t lk;
	lk_t next_lk;

	logic        convDone;
	logic [12:0] rawCode;
	logic [4:0]  edgeCount;
	logic        access;

	////////////////////////////////////////////////////////////////////
	// Functions
	function automatic logic [12:0] codeOut(input logic [12:0] twos,
		input logic straight);
		codeOut = straight ? {~twos[12], twos[11:0]} : twos;
	endfunction

	function automatic logic [5:0] route(input logic [1:0] mode,
		input logic [1:0] chan);
		route = {chan, 2'h0, 1'b1, 1'b0};
		unique case (mode)
			MODE_SINGLE:
				route = {chan, 2'h0, 1'b1, 1'b0};
			MODE_DIFF2:
				route = {chan[1], 1'b0, chan[1], 1'b1, 1'b0, 1'b1};
			MODE_PSEUDO2:
				route = {chan[1], 1'b0, chan[1], 1'b1, 1'b0, 1'b0};
			MODE_PSEUDO3:
				route = {(chan == 2'h3) ? 2'h2 : chan, 2'h3, 1'b0, 1'b0};
		endcase
	endfunction

	function automatic logic [31:0] ctrlWord(input ck_t s);
		ctrlWord = '0;
		ctrlWord[CTRL_MODE_LSB +: 2]    = s.mode;
		ctrlWord[CTRL_REF_BIT]          = s.refSel;
		ctrlWord[CTRL_PD_LSB +: 2]      = s.pdMode;
		ctrlWord[CTRL_CODING_BIT]       = s.coding;
		ctrlWord[CTRL_SEQ_BIT]          = s.seqOn;
		ctrlWord[CTRL_CHAN_LSB +: 2]    = s.chanSel;
		ctrlWord[CTRL_SEQLAST_LSB +: 2] = s.seqLast;
	endfunction

	function automatic logic [1:0] nextChan(input logic [1:0] chan,
		input logic [1:0] last);
		nextChan = (chan >= last) ? 2'h0 : 2'(chan + 2'h1);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Converter sequencer on the serial clock
	sar_convert_engine u_sar_convert_engine (
		.sclk      (sclk),
		.csN       (csN),
		.compHigh  (compHigh),
		.dacCode   (dacCode),
		.holdOn    (holdOn),
		.convDone  (convDone),
		.result    (rawCode),
		.edgeCount (edgeCount)
	);

	////////////////////////////////////////////////////////////////////
	// Register domain: bus slave, result capture, power control
	assign access = cyc_i && stb_i && !ck.ack;

	always_comb
	begin
		next_ck = ck;
		next_ck.ack = access;
		next_ck.csS1 = csN;
		next_ck.csS2 = ck.csS1;
		next_ck.resS1 = lk.resToggle;
		next_ck.resS2 = ck.resS1;
		if (access && we_i)
		begin
			if (adr_i == CTRL_ADDR)
			begin
				if (sel_i[0])
				begin
					next_ck.mode = dat_i[CTRL_MODE_LSB +: 2];
					next_ck.refSel = dat_i[CTRL_REF_BIT];
					next_ck.pdMode = dat_i[CTRL_PD_LSB +: 2];
					next_ck.coding = dat_i[CTRL_CODING_BIT];
					next_ck.seqOn = dat_i[CTRL_SEQ_BIT];
					next_ck.chanSel[0] = dat_i[CTRL_CHAN_LSB];
				end
				if (sel_i[1])
				begin
					next_ck.chanSel[1] = dat_i[CTRL_CHAN_LSB + 1];
					next_ck.seqLast = dat_i[CTRL_SEQLAST_LSB +: 2];
				end
				next_ck.cfgToggle = !ck.cfgToggle;
			end
			else if (adr_i == RANGE_ADDR)
			begin
				if (sel_i[0])
					next_ck.range = dat_i[7:0];
				next_ck.cfgToggle = !ck.cfgToggle;
			end
		end
		if (access && !we_i)
		begin
			unique case (adr_i)
				CTRL_ADDR:
					next_ck.rdData = ctrlWord(ck);
				RANGE_ADDR:
					next_ck.rdData = {24'h0, ck.range};
				STATUS_ADDR:
				begin
					next_ck.rdData = {13'h0, ck.refBufOn, ck.coreOn,
						ck.fresh, ck.result};
					next_ck.fresh = 1'b0;
				end
				default:
					next_ck.rdData = 32'h0;
			endcase
		end
		if (ck.resS2 != ck.resSeen)
		begin
			next_ck.resSeen = ck.resS2;
			next_ck.result = lk.resWord;
			next_ck.fresh = 1'b1;
		end
		unique case (ck.pdMode)
			PD_NORMAL:
			begin
				next_ck.coreOn = 1'b1;
				next_ck.refBufOn = ck.refSel;
			end
			PD_STANDBY:
			begin
				next_ck.coreOn = !ck.csS2;
				next_ck.refBufOn = ck.refSel;
			end
			PD_SHUTDOWN:
			begin
				next_ck.coreOn = !ck.csS2;
				next_ck.refBufOn = ck.refSel && !ck.csS2;
			end
			PD_FULL:
			begin
				next_ck.coreOn = 1'b0;
				next_ck.refBufOn = 1'b0;
			end
		endcase
		if (sys_rst)
		begin
			next_ck = '0;
			next_ck.mode = MODE_RESET;
			next_ck.refSel = REF_RESET;
			next_ck.pdMode = PD_RESET;
			next_ck.coding = CODING_RESET;
			next_ck.range = RANGE_RESET;
		end
	end

	always_ff @(posedge clock)
	begin
		ck <= next_ck;
	end

	////////////////////////////////////////////////////////////////////
	// Link domain: configuration snapshot, coding, sequence, shift out
	always_comb
	begin
		next_lk = lk;
		next_lk.rstS1 = sys_rst;
		next_lk.rstS2 = lk.rstS1;
		next_lk.cfgS1 = ck.cfgToggle;
		next_lk.cfgS2 = lk.cfgS1;
		next_lk.prevDone = convDone;
		if (convDone && !lk.prevDone)
		begin
			next_lk.resWord = {1'b0, lk.chan,
				codeOut(rawCode, lk.coding)};
			next_lk.resToggle = !lk.resToggle;
			if (lk.seqOn)
				next_lk.chan = nextChan(lk.chan, lk.seqLast);
		end
		if (lk.cfgS2 != lk.cfgSeen)
		begin
			next_lk.cfgSeen = lk.cfgS2;
			next_lk.mode = ck.mode;
			next_lk.coding = ck.coding;
			next_lk.seqOn = ck.seqOn;
			next_lk.seqLast = ck.seqLast;
			next_lk.range = ck.range;
			next_lk.chan = ck.seqOn ? 2'h0 : ck.chanSel;
		end
		if (edgeCount == 5'h00)
			next_lk.shift = lk.resWord;
		else
			next_lk.shift = {lk.shift[14:0], 1'b0};
		{next_lk.muxPos, next_lk.muxNeg, next_lk.negGround,
			next_lk.diffMode} = route(next_lk.mode, next_lk.chan);
		next_lk.rangeSel = next_lk.range[{next_lk.chan, 1'b0} +: 2];
		if (lk.rstS2)
		begin
			next_lk = '0;
			next_lk.rstS1 = sys_rst;
			next_lk.rstS2 = lk.rstS1;
			next_lk.cfgS1 = ck.cfgToggle;
			next_lk.cfgS2 = lk.cfgS1;
			next_lk.cfgSeen = lk.cfgS2;
			next_lk.mode = MODE_RESET;
			next_lk.coding = CODING_RESET;
			next_lk.range = RANGE_RESET;
			next_lk.negGround = 1'b1;
		end
	end

	always_ff @(posedge sclk)
	begin
		lk <= next_lk;
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign ack_o       = ck.ack;
	assign dat_o       = ck.rdData;
	assign dout        = lk.shift[15];
	assign muxPos      = lk.muxPos;
	assign muxNeg      = lk.muxNeg;
	assign negGround   = lk.negGround;
	assign diffMode    = lk.diffMode;
	assign rangeSel    = lk.rangeSel;
	assign refInternal = ck.refSel;
	assign coreOn      = ck.coreOn;
	assign refBufOn    = ck.refBufOn;

endmodule // sar_adc_config_control

// file: test/sar_adc_assertions.sv
// Purpose: Port timing checks of the converter control block
// Assumes: Link edges are counted here for each frame
// Notes:   Bound to every control block instance
`timescale 1ns/1ps
module sar_adc_assertions
	import sar_adc_pkg::*;
(
	// Bus side
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic        refInternal,
	// Link side
	input wire logic        sclk,
	input wire logic        csN,
	input wire logic [12:0] dacCode,
	input wire logic        holdOn
);
	logic [4:0] edges;

	always_ff @(posedge sclk or posedge csN)
		if (csN)
			edges <= 5'h00;
		else if (edges != 5'h1F)
			edges <= edges + 5'h01;
	////////////////////////////////////////////////////////////////////
	property p_ack_answer;
		@(posedge clock) disable iff (sys_rst)
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer)
		else $error("request not answered");
	property p_ack_pulse;
		@(posedge clock) disable iff (sys_rst)
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("answer held too long");
	property p_ack_cause;
		@(posedge clock) disable iff (sys_rst)
		ack_o |-> $past(cyc_i && stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("answer without request");
	property p_reset_ref;
		@(posedge clock) disable iff (sys_rst)
		$past(sys_rst) |-> !refInternal && !ack_o;
	endproperty
	a_reset_ref: assert property (p_reset_ref)
		else $error("internal reference after reset");
	property p_idle;
		@(posedge clock) disable iff (sys_rst)
		csN |-> !holdOn;
	endproperty
	a_idle: assert property (p_idle)
		else $error("hold outside frame");
	property p_start;
		@(posedge sclk) disable iff (csN)
		!csN && edges == 5'h00 |-> holdOn && dacCode == SAR_START;
	endproperty
	a_start: assert property (p_start)
		else $error("frame start wrong");
	property p_hold;
		@(posedge sclk) disable iff (csN)
		!csN && edges inside {[5'h01:5'h0D]} |-> holdOn;
	endproperty
	a_hold: assert property (p_hold)
		else $error("hold dropped early");
	property p_track;
		@(posedge sclk) disable iff (csN)
		!csN && edges >= TRACK_EDGE |-> !holdOn;
	endproperty
	a_track: assert property (p_track)
		else $error("no return to track");
	c_frame: cover property (@(posedge sclk) !csN && edges == 5'h10);
	c_ref: cover property (@(posedge clock) refInternal);
	c_ack: cover property (@(posedge clock) $rose(ack_o));
endmodule // sar_adc_assertions

bind sar_adc_config_control sar_adc_assertions u_sar_adc_assertions (
	.clock(clock), .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i),
	.ack_o(ack_o), .refInternal(refInternal), .sclk(sclk), .csN(csN),
	.dacCode(dacCode), .holdOn(holdOn)
);

// file: test/serial_host_model.sv
// Purpose: Serial host and comparator on the converter link
// Assumes: Link clock runs in frames and for a while after start
// Notes:   Comparator trips at the requested offset-binary level
`timescale 1ns/1ps
module serial_host_model
	import sar_adc_pkg::*;
(
	// Bench control
	input  wire logic        go,
	input  wire logic [12:0] level,
	// Converter side
	input  wire logic [12:0] dacCode,
	input  wire logic        dout,
	output      logic        sclk,
	output      logic        csN,
	output      logic        compHigh,
	output      logic [15:0] word,
	output      logic        done
);
	assign compHigh = level >= dacCode;
	initial
	begin
		{sclk, csN, done} = 3'h2;
		word = 16'h0000;
		repeat (12)
		begin
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
		end
		forever
		begin
			@(posedge go);
			done = 1'b0;
			#37 csN = 1'b0;
			repeat (16)
			begin
				#80 sclk = 1'b1;
				#80 sclk = 1'b0;
				word = {word[14:0], dout};
			end
			#80 csN = 1'b1;
			done = 1'b1;
		end
	end
endmodule // serial_host_model

// file: test/tb_top.sv
// Purpose: Self-checking bench of the converter control block
// Assumes: Host model runs the link clock in frames and for 12 cycles at start
// Notes:   Bus reads and frame words are scored from queues
`timescale 1ns/1ps
module tb_top
	import sar_adc_pkg::*;
;
	typedef struct packed {logic [31:0] v; logic [31:0] m;} note_t;
	logic        clock, sys_rst, cyc_i, stb_i, we_i, ack_o, go, done;
	logic        sclk, csN, dout, compHigh, holdOn, refInternal;
	logic [3:0]  sel_i;
	logic [7:0]  adr_i;
	logic [31:0] dat_i, dat_o, r;
	logic [12:0] dacCode, level, lv, ex;
	logic [15:0] word;
	logic [15:0] pv;
	logic [7:0]  rg;
	logic [1:0]  muxPos, muxNeg, rangeSel, md;
	logic        coreOn, refBufOn, negGround, diffMode;
	logic [15:0] frameQ[$];
	note_t       rdQ[$];
	note_t       nt;
	int          miscompares, testsRun, cycles, seed, i;

	sar_adc_config_control u_sar_adc_config_control (
		.clock(clock), .sys_rst(sys_rst), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
		.ack_o(ack_o), .dat_o(dat_o), .sclk(sclk), .csN(csN), .dout(dout),
		.compHigh(compHigh), .dacCode(dacCode), .holdOn(holdOn),
		.muxPos(muxPos), .muxNeg(muxNeg), .negGround(negGround),
		.diffMode(diffMode), .rangeSel(rangeSel),
		.refInternal(refInternal), .coreOn(coreOn), .refBufOn(refBufOn)
	);
	serial_host_model u_serial_host_model (
		.go(go), .level(level), .dacCode(dacCode), .dout(dout),
		.sclk(sclk), .csN(csN), .compHigh(compHigh), .word(word), .done(done)
	);
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock)
		if (++cycles == 3000)
			complete_run(1);
	always @(posedge clock)
		if (ack_o && !we_i && rdQ.size() > 0)
		begin
			nt = rdQ.pop_front();
			chk(dat_o & nt.m, nt.v);
		end
	always @(posedge done)
		if (frameQ.size() > 0)
			chk({16'h0, word}, {16'h0, frameQ.pop_front()});
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		testsRun++;
		if (seen !== want)
		begin
			miscompares++;
			$display("mismatch %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, logic [31:0] d);
		int n = 0;
		@(posedge clock);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
		do
			@(posedge clock);
		while (ack_o !== 1'b1 && ++n < 50);
		if (n >= 50)
			complete_run(1);
		{cyc_i, stb_i} <= 2'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v, m);
		rdQ.push_back({v & m, m});
		wb(1'b0, a, 32'h0);
	endtask
	task automatic frame(input logic [12:0] l);
		int n = 0;
		@(posedge clock);
		{go, level} <= {1'b1, l};
		do
			@(posedge clock);
		while (done !== 1'b1 && ++n < 100);
		if (n >= 100)
			complete_run(1);
		go <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	task automatic complete_run(input int late);
		miscompares += late;
		$display("miscompares %0d testsRun %0d", miscompares, testsRun);
		if (miscompares == 0 && testsRun > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		{cyc_i, stb_i, we_i, go, sys_rst} = 5'h01;
		{adr_i, dat_i, level} = 53'h0;
		sel_i = 4'hF;
		seed = 71578;
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		rd(CTRL_ADDR, 32'h0, 32'h7FF);
		rd(8'h0C, 32'h0, 32'hFFFFFFFF);
		for (i = 0; i < 16; i++)
		begin
			r = $random(seed);
			wb(1'b1, RANGE_ADDR, r);
			rd(RANGE_ADDR, r, 32'hFF);
			rg = r[7:0];
			wb(1'b1, CTRL_ADDR, {27'h0, i[3:2], i[0], i[1:0]});
			rd(CTRL_ADDR, {27'h0, i[3:2], i[0], i[1:0]}, 32'h7FF);
			chk({31'h0, refInternal}, {31'h0, i[0]});
			chk({31'h0, coreOn}, {31'h0, i[3:2] == PD_NORMAL});
			chk({31'h0, refBufOn}, {31'h0, i[0] && i[3:2] <= PD_STANDBY});
		end
		for (i = 0; i < 6; i++)
		begin
			r = $random(seed);
			lv = i == 0 ? 13'h0000 : i == 1 ? 13'h1FFF : r[12:0];
			md = i[1:0];
			wb(1'b1, CTRL_ADDR, {26'h0, i[1], 3'h0, md});
			frame(lv);
			ex = i[1] ? lv : lv ^ SAR_START;
			rd(STATUS_ADDR, {15'h0, 1'b1, 3'h0, ex}, 32'h1FFFF);
			chk({31'h0, negGround}, {31'h0, md == MODE_SINGLE});
			chk({31'h0, diffMode}, {31'h0, md == MODE_DIFF2});
			chk({30'h0, rangeSel}, {30'h0, rg[1:0]});
			frameQ.push_back({3'h0, ex});
			frame(lv);
		end
		wb(1'b1, CTRL_ADDR, 32'h660);
		for (i = 0; i < 4; i++)
		begin
			r = $random(seed);
			if (i > 0)
				frameQ.push_back(pv);
			frame(r[12:0]);
			pv = {1'b0, i[1:0], r[12:0]};
			rd(STATUS_ADDR, {15'h0, 1'b1, pv}, 32'h1FFFF);
			chk({30'h0, muxPos}, {30'h0, 2'(i + 1)});
			chk({30'h0, muxNeg}, 32'h0);
			chk({31'h0, negGround}, 32'h1);
			chk({30'h0, rangeSel}, {30'h0, rg[2 * ((i + 1) % 4) +: 2]});
		end
		complete_run(0);
	end
endmodule // tb_top
